// *** emb_defs.svh ***
// Constants for the external memory bus interface
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH
`define EMB_REG_SETUP 4'h0
`define EMB_REG_STATUS 4'h1
`define EMB_SETUP_IGNORE_BIT 4
`define EMB_SETUP_SHUTOFF_BIT 3
`define EMB_SETUP_W16_BIT 2
`define EMB_SHAPE_STRAP_W16 3'h7
`define EMB_SHAPE_STRAP_W8 3'h3
`define EMB_SHAPE_RSVD_A 3'h4
`define EMB_SHAPE_RSVD_B 3'h5
`define EMB_STATUS_EXT_BIT 0
`define EMB_STATUS_W16_BIT 1
`define EMB_STATUS_BUSY_BIT 2
`define EMB_CODE_LIMIT 24'h008000
`endif

// *** emb_pkg.sv ***
// Types for the external memory bus interface
`default_nettype none
package emb_pkg;
	typedef enum logic [1:0] {
		EMB_CODE,
		EMB_READ,
		EMB_WRITE
	} emb_kind_t;
	typedef struct packed {
		emb_kind_t kind;
		logic word;
		logic [23:0] addr;
		logic [15:0] wdata;
	} emb_req_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ALE,
		ST_STB,
		ST_GAP,
		ST_REST
	} emb_state_t;
endpackage
`default_nettype wire

// *** emb_bus.sv ***
// External memory bus master: strobes, latch pulse, multiplexed lines, setup register
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "emb_defs.svh"
`default_nettype none
module emb_bus (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Straps
	input wire logic external_fetch_select_n,
	input wire logic width_strap,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Core request port
	input wire logic req_valid,
	input wire emb_pkg::emb_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic resp_skipped,
	output logic [15:0] resp_rdata,
	// Bus pins
	output logic [3:0] addr_lo,
	output logic [3:0] addr_hi,
	output logic [15:0] ad_out,
	output logic ad_oe,
	input wire logic [15:0] ad_in,
	output logic ale,
	output logic code_read_strobe_n,
	output logic data_read_strobe_n,
	output logic low_byte_write_strobe_n,
	output logic high_byte_write_strobe_n,
	input wire logic wait_in
);
	import emb_pkg::*;

	// Mask address by shape field
	function automatic logic [23:0] shape_mask(input logic [2:0] shape, input logic [23:0] a);
		logic [23:0] m;
		m = 24'hFFFFFF;
		case (shape[1:0])
			2'h0: m = shape[2] ? 24'h0FFFFF : 24'h000FFF;
			2'h1: m = shape[2] ? 24'hFFFFFF : 24'h00FFFF;
			2'h2: m = 24'h0FFFFF;
			default: m = 24'hFFFFFF;
		endcase
		return a & m;
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	emb_state_t state_r, state_nxt;
	emb_req_t cur_r, cur_nxt;
	logic second_r, second_nxt;
	logic [4:0] setup_r;
	logic ext_all_r;
	logic strap_pend_r;
	logic resp_r, resp_nxt;
	logic skip_r, skip_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [7:0] rd_r;

	wire w16 = setup_r[`EMB_SETUP_W16_BIT];
	wire shutoff = setup_r[`EMB_SETUP_SHUTOFF_BIT];
	wire wait_eff = wait_in & ~setup_r[`EMB_SETUP_IGNORE_BIT];
	wire need_two = ~w16 & cur_r.word & (cur_r.kind != EMB_WRITE || 1'b1);
	wire last_part = ~need_two | second_r;
	wire stb_done = (state_r == ST_STB) & ~wait_eff;
	wire is_code_req = req.kind == EMB_CODE;
	// Internal code below the limit never touches the bus
	wire below_limit = is_code_req & ~ext_all_r & (req.addr < `EMB_CODE_LIMIT);
	wire bypass = shutoff | below_limit;
	wire [23:0] cur_end = {cur_r.addr[23:1], cur_r.addr[0] | cur_r.word};
	wire [23:0] seq_addr = cur_end + 24'h000001;
	// Burst continues only inside the same 16-byte window
	wire burst_ok = stb_done & last_part & (cur_r.kind == EMB_CODE) & is_code_req & ~bypass
		& (req.addr == seq_addr) & (req.addr[23:4] == cur_r.addr[23:4]);
	assign req_ready = (state_r == ST_IDLE) | burst_ok;
	wire take = req_valid & req_ready;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cur_nxt = cur_r;
		second_nxt = second_r;
		resp_nxt = 1'b0;
		skip_nxt = 1'b0;
		rdata_nxt = rdata_r;
		case (state_r)
			ST_IDLE: begin
				if (take && bypass) begin
					resp_nxt = 1'b1;
					skip_nxt = 1'b1;
					rdata_nxt = 16'h0000;
				end else if (take) begin
					cur_nxt = req;
					second_nxt = 1'b0;
					state_nxt = ST_ALE;
				end
			end
			ST_ALE: begin
				state_nxt = ST_STB;
			end
			ST_STB: begin
				if (!wait_eff) begin
					if (cur_r.kind != EMB_WRITE) begin
						if (w16) begin
							rdata_nxt = ad_in;
						end else if (second_r) begin
							rdata_nxt = {ad_in[7:0], rdata_r[7:0]};
						end else begin
							rdata_nxt = {8'h00, ad_in[7:0]};
						end
					end
					if (!last_part) begin
						second_nxt = 1'b1;
						state_nxt = ST_GAP;
					end else begin
						resp_nxt = 1'b1;
						if (take) begin
							cur_nxt = req;
							second_nxt = 1'b0;
						end else begin
							state_nxt = ST_REST;
						end
					end
				end
			end
			ST_GAP: begin
				state_nxt = ST_STB;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cur_r <= '0;
			second_r <= 1'b0;
			resp_r <= 1'b0;
			skip_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
			second_r <= second_nxt;
			resp_r <= resp_nxt;
			skip_r <= skip_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign resp_valid = resp_r;
	assign resp_skipped = skip_r;
	assign resp_rdata = rdata_r;

	// ------------------------------------------------------------
	// Straps and setup register
	// ------------------------------------------------------------
	// Sync reset: straps caught on first edge after release
	wire setup_wr = reg_wr & (reg_addr == `EMB_REG_SETUP);
	wire rsvd_shape = (reg_wdata[2:0] == `EMB_SHAPE_RSVD_A) | (reg_wdata[2:0] == `EMB_SHAPE_RSVD_B);
	wire [2:0] shape_wr = rsvd_shape ? setup_r[2:0] : reg_wdata[2:0];
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_pend_r <= 1'b1;
			ext_all_r <= 1'b0;
			setup_r <= {2'b00, `EMB_SHAPE_STRAP_W16};
		end else if (strap_pend_r) begin
			strap_pend_r <= 1'b0;
			ext_all_r <= ~external_fetch_select_n;
			setup_r[2:0] <= width_strap ? `EMB_SHAPE_STRAP_W16 : `EMB_SHAPE_STRAP_W8;
		end else if (setup_wr) begin
			setup_r <= {reg_wdata[4:3], shape_wr};
		end
	end

	wire [7:0] status_word = {5'h00, (state_r != ST_IDLE), w16, ext_all_r};
	wire [7:0] rd_sel = (reg_addr == `EMB_REG_SETUP) ? {3'b000, setup_r} :
		(reg_addr == `EMB_REG_STATUS) ? status_word : 8'h00;
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_r <= 8'h00;
		end else begin
			rd_r <= reg_rd ? rd_sel : 8'h00;
		end
	end
	assign reg_rdata = rd_r;

	// ------------------------------------------------------------
	// Pins, registered from next state
	// ------------------------------------------------------------
	wire n_stb = state_nxt == ST_STB;
	wire n_w16 = (state_r == ST_IDLE) ? w16 : w16;
	wire [23:0] n_addr = shape_mask(setup_r[2:0], {cur_nxt.addr[23:1], cur_nxt.addr[0] | second_nxt});
	wire n_lo_lane = ~n_w16 | cur_nxt.word | ~cur_nxt.addr[0];
	wire n_hi_lane = n_w16 & (cur_nxt.word | cur_nxt.addr[0]);
	wire n_wr = n_stb & (cur_nxt.kind == EMB_WRITE);
	wire [15:0] n_wdata = n_w16 ? cur_nxt.wdata :
		(second_nxt ? {8'h00, cur_nxt.wdata[15:8]} : {8'h00, cur_nxt.wdata[7:0]});
	wire [15:0] n_ad = (state_nxt == ST_ALE) ? n_addr[19:4] : n_wdata;
	wire n_oe = (state_nxt == ST_ALE) | ((n_stb | state_nxt == ST_GAP) & (cur_nxt.kind == EMB_WRITE));

	always_ff @(posedge clk) begin
		if (reset) begin
			addr_lo <= 4'h0;
			addr_hi <= 4'h0;
			ad_out <= 16'h0000;
			ad_oe <= 1'b0;
			ale <= 1'b0;
			code_read_strobe_n <= 1'b1;
			data_read_strobe_n <= 1'b1;
			low_byte_write_strobe_n <= 1'b1;
			high_byte_write_strobe_n <= 1'b1;
		end else begin
			addr_lo <= n_addr[3:0];
			addr_hi <= n_addr[23:20];
			ad_out <= n_ad;
			ad_oe <= n_oe;
			ale <= state_nxt == ST_ALE;
			code_read_strobe_n <= ~(n_stb & (cur_nxt.kind == EMB_CODE));
			data_read_strobe_n <= ~(n_stb & (cur_nxt.kind == EMB_READ));
			low_byte_write_strobe_n <= ~(n_wr & n_lo_lane);
			high_byte_write_strobe_n <= ~(n_wr & n_hi_lane);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_CODE_ONLY_FETCH: assert property (@(posedge clk) disable iff (reset)
		!code_read_strobe_n |-> (state_r == ST_STB) && (cur_r.kind == EMB_CODE))
		else $error("code strobe low outside a code fetch");
	AST_READ_STROBE: assert property (@(posedge clk) disable iff (reset)
		!data_read_strobe_n |-> (state_r == ST_STB) && (cur_r.kind == EMB_READ))
		else $error("read strobe low outside a data read");
	AST_LOW_LANE: assert property (@(posedge clk) disable iff (reset)
		(!low_byte_write_strobe_n && w16 && !cur_r.word) |-> !cur_r.addr[0])
		else $error("low strobe on odd byte of wide bus");
	AST_HIGH_WIDE_ONLY: assert property (@(posedge clk) disable iff (reset)
		!high_byte_write_strobe_n |-> w16 && (cur_r.word || cur_r.addr[0]))
		else $error("high strobe without wide bus or odd byte");
	AST_ALE_BEFORE_STROBE: assert property (@(posedge clk) disable iff (reset)
		ale |-> ad_oe && code_read_strobe_n && data_read_strobe_n ##1 !ale)
		else $error("latch pulse overlaps strobe or lines not driven");
	AST_WAIT_HOLDS: assert property (@(posedge clk) disable iff (reset)
		(state_r == ST_STB && wait_eff) |=> (state_r == ST_STB) && $stable(cur_r))
		else $error("wait did not stretch the strobe");
	AST_IGNORE_WAIT: assert property (@(posedge clk) disable iff (reset)
		(state_r == ST_STB && setup_r[`EMB_SETUP_IGNORE_BIT]) |=> resp_r || (state_r == ST_GAP))
		else $error("strobe stretched while wait ignored");
	AST_SHUTOFF_IDLE: assert property (@(posedge clk) disable iff (reset)
		(shutoff && state_r == ST_IDLE) |=> (state_r == ST_IDLE) && !ale)
		else $error("bus activity while shut off");
	AST_REST_CLOCK: assert property (@(posedge clk) disable iff (reset)
		(state_r == ST_REST) |-> ##1 (state_r == ST_IDLE) && !ale && !req_ready ##0 1'b1 or ##1 1'b1)
		else $error("no rest clock after cycle");
	AST_MODE_STABLE: assert property (@(posedge clk) disable iff (reset)
		!strap_pend_r && !$past(strap_pend_r) |-> $stable(ext_all_r))
		else $error("fetch mode changed after reset release");
	AST_SECOND_BYTE: assert property (@(posedge clk) disable iff (reset)
		(state_r == ST_GAP) |-> !ale ##1 (state_r == ST_STB) && addr_lo[0])
		else $error("second byte not at odd address without pulse");
endmodule
`default_nettype wire

// *** emb_mem_model.sv ***
// Far-side model: address latch, byte memory, slow device with stall output
`default_nettype none
module emb_mem_model (
	// Clock
	input wire logic clk,
	// Bus from the master
	input wire logic [3:0] addr_lo,
	input wire logic [3:0] addr_hi,
	input wire logic [15:0] ad_out,
	input wire logic ale,
	input wire logic code_read_strobe_n,
	input wire logic data_read_strobe_n,
	input wire logic low_byte_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	// Stall length in cycles
	input wire logic [7:0] wait_len,
	// Answers to the master
	output logic [15:0] ad_in,
	output logic wait_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] lat_r = '0;
	logic [23:0] a_seen = '0;
	logic [7:0] wcnt_r = 8'h00;
	logic [15:0] junk_r = 16'h5A5A;
	logic [7:0] mem [256];
	wire logic rd_now = !code_read_strobe_n || !data_read_strobe_n;
	wire logic wr_now = !low_byte_write_strobe_n || !high_byte_write_strobe_n;
	wire logic [23:0] cur_a = {lat_r, addr_lo};
	// Released lines toggle so a stale sample never looks valid
	assign ad_in = rd_now ? {{cur_a[7:1], 1'b1} ^ 8'h5A, cur_a[7:0] ^ 8'h5A} : junk_r;
	assign wait_in = (rd_now || wr_now) && wcnt_r < wait_len;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
	end
	always @(posedge clk) begin
		junk_r <= ~junk_r;
		if (ale) lat_r <= {addr_hi, ad_out};
		if (rd_now || wr_now) a_seen <= cur_a;
		if (!low_byte_write_strobe_n) mem[cur_a[7:0]] <= ad_out[7:0];
		if (!high_byte_write_strobe_n) mem[{cur_a[7:1], 1'b1}] <= ad_out[15:8];
		wcnt_r <= (rd_now || wr_now) ? wcnt_r + 8'h01 : 8'h00;
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the external memory bus master
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import emb_pkg::*;
	logic clk = 1'b0, reset = 1'b1, external_fetch_select_n = 1'b0, width_strap = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, skp;
	logic [3:0] reg_addr = 4'h0, addr_lo, addr_hi;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, wait_len = 8'h00, rv;
	emb_req_t req = '0;
	logic req_ready, resp_valid, resp_skipped, ad_oe, ale, wait_in;
	logic code_read_strobe_n, data_read_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n;
	logic [15:0] ad_out, ad_in, resp_rdata, rd;
	int fails = 0, n_tests = 0, cyc = 0, n_ale, n_strb, n_code;
	emb_bus dut (.clk, .reset, .external_fetch_select_n, .width_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .req_valid, .req, .req_ready, .resp_valid, .resp_skipped, .resp_rdata, .addr_lo, .addr_hi,
		.ad_out, .ad_oe, .ad_in, .ale, .code_read_strobe_n, .data_read_strobe_n, .low_byte_write_strobe_n,
		.high_byte_write_strobe_n, .wait_in);
	emb_mem_model far (.clk, .addr_lo, .addr_hi, .ad_out, .ale, .code_read_strobe_n, .data_read_strobe_n,
		.low_byte_write_strobe_n, .high_byte_write_strobe_n, .wait_len, .ad_in, .wait_in);
	initial forever #10 clk = ~clk;
	// ----------------------------------------
	// Bus activity counters and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (ale) n_ale++;
		if (!code_read_strobe_n) n_code++;
		if (!(data_read_strobe_n && low_byte_write_strobe_n && high_byte_write_strobe_n)) n_strb++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	function automatic logic [7:0] fb(input logic [23:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	task automatic rst(input logic e, input logic w);
		reset <= 1'b1;
		external_fetch_select_n <= e;
		width_strap <= w;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rv = reg_rdata;
	endtask
	// Request held until taken; answer sampled mid-cycle
	task automatic xfer(input emb_kind_t k, input logic w, input logic [23:0] a, input logic [15:0] d);
		n_ale = 0;
		n_strb = 0;
		n_code = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{kind: k, word: w, addr: a, wdata: d};
		@(negedge clk);
		for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
		for (int i = 0; i < 300 && resp_valid !== 1'b1; i++) @(negedge clk);
		rd = resp_rdata;
		skp = resp_skipped;
		@(posedge clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		rdr(4'h0);
		`CHK("setup rst", 8'h07, rv)
		rdr(4'h1);
		`CHK("status w16", 1'b1, rv[1])
		wr(4'h0, 8'hE6);
		rdr(4'h0);
		`CHK("setup rsvd", 8'h06, rv)
		wr(4'h0, 8'h04);
		rdr(4'h0);
		`CHK("shape rsvd", 8'h06, rv)
		rdr(4'hF);
		`CHK("unmapped", 8'h00, rv)
	endtask
	task automatic t_read16;
		wait_len = 8'h02;
		xfer(EMB_READ, 1'b1, 24'h012344, 16'h0000);
		`CHK("rd16 data", {fb(24'h012345), fb(24'h012344)}, rd)
		`CHK("rd16 stretch", 3, n_strb)
		`CHK("rd16 ale", 1, n_ale)
		`CHK("rd16 code", 0, n_code)
		`CHK("rd16 addr", 24'h012344, far.a_seen)
		wait_len = 8'h00;
	endtask
	task automatic t_wr16;
		xfer(EMB_WRITE, 1'b0, 24'h010010, 16'h003C);
		xfer(EMB_WRITE, 1'b0, 24'h010013, 16'hC300);
		xfer(EMB_WRITE, 1'b1, 24'h010014, 16'hBEEF);
		`CHK("even byte", 8'h3C, far.mem[8'h10])
		`CHK("even lane only", 8'h00, far.mem[8'h11])
		`CHK("odd lane only", 8'h00, far.mem[8'h12])
		`CHK("odd byte", 8'hC3, far.mem[8'h13])
		`CHK("word", 16'hBEEF, {far.mem[8'h15], far.mem[8'h14]})
	endtask
	task automatic t_bus8;
		wr(4'h0, 8'h03);
		rdr(4'h1);
		`CHK("sw width", 1'b0, rv[1])
		xfer(EMB_READ, 1'b1, 24'h000120, 16'h0000);
		`CHK("rd8 data", {fb(24'h000121), fb(24'h000120)}, rd)
		`CHK("rd8 ale", 1, n_ale)
		xfer(EMB_WRITE, 1'b1, 24'h000130, 16'hA1B2);
		`CHK("wr8 word", 16'hA1B2, {far.mem[8'h31], far.mem[8'h30]})
		`CHK("wr8 strobes", 2, n_strb)
	endtask
	task automatic t_code_ext;
		xfer(EMB_CODE, 1'b1, 24'h000200, 16'h0000);
		`CHK("ext fetch", 1'b0, skp)
		`CHK("code strobe", 1'b1, n_code > 0)
		`CHK("code data", {fb(24'h000201), fb(24'h000200)}, rd)
	endtask
	task automatic t_ignore;
		wr(4'h0, 8'h17);
		wait_len = 8'hC8;
		xfer(EMB_READ, 1'b0, 24'h000140, 16'h0000);
		`CHK("ignore wait", 1, n_strb)
		wait_len = 8'h00;
	endtask
	task automatic t_internal;
		rst(1'b1, 1'b0);
		external_fetch_select_n <= 1'b0;
		rdr(4'h0);
		`CHK("strap 8", 8'h03, rv)
		xfer(EMB_CODE, 1'b1, 24'h000100, 16'h0000);
		`CHK("int skip", 1'b1, skp)
		`CHK("int quiet", 0, n_code)
		xfer(EMB_CODE, 1'b1, 24'h008000, 16'h0000);
		`CHK("above limit", 1'b0, skp)
	endtask
	task automatic t_shut;
		wr(4'h0, 8'h0B);
		xfer(EMB_READ, 1'b0, 24'h000150, 16'h0000);
		`CHK("shut skip", 1'b1, skp)
		`CHK("shut quiet", 0, n_strb + n_ale + n_code)
	endtask
	task automatic print_verdict;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		rst(1'b0, 1'b1);
		t_regs();
		t_read16();
		t_wr16();
		t_bus8();
		t_code_ext();
		t_ignore();
		t_internal();
		t_shut();
		print_verdict();
	end
endmodule
`default_nettype wire
